// [bench/testbench.sv]
// Self-checking bench for the wake interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, reset, wr_en, rd_en, tel_sel, ser_sel, clk_en;
    logic        tel_a, tel_b, ser_one, ser_ls;
    logic [31:0] lvl, wdata, rdata, line, got;
    logic [11:0] addr, base;
    logic [7:0]  gpio_pin;
    logic [2:0]  lan;
    logic [1:0]  lan_idx, wake_req, irq;
    int          err_total, samples_checked, seed, b, k, s;
    int unsigned st_m[2], mk_m[2], v;

    always #4 clk = ~clk;

    wia_src_model src (.lvl(lvl), .tel_sel(tel_sel), .ser_sel(ser_sel),
        .lan_idx(lan_idx), .line(line), .tel_a(tel_a), .tel_b(tel_b),
        .ser_one(ser_one), .ser_ls(ser_ls), .lan(lan));
    wia_top dut (.clk(clk), .reset(reset), .clk_en(clk_en),
        .general_irq_line(line[7:0]), .gpio_pin(gpio_pin),
        .timer_event(line[11:8]), .telephony_device_irq_a(tel_a),
        .telephony_device_irq_b(tel_b), .telephony_sel_b(tel_sel),
        .clock_alarm_event(line[13]), .clock_periodic_event(line[14]),
        .pcie_ctrl_zero_event(line[15]), .pcie_ctrl_one_event(line[16]),
        .sata_ctrl_event(line[17]), .sata_message_signalled_event(line[18]),
        .usb_two_ctrl_event(line[19]), .usb_three_ctrl_event(line[20]),
        .usb_three_power_event(line[28]), .packet_host_if_event(line[21]),
        .packet_host_nocopy_event(line[27]), .lan_wakeup_event(lan),
        .voice_subsystem_event(line[23]), .peripheral_dma_event(line[24]),
        .serial_port_zero_event(line[25]), .serial_port_one_event(ser_one),
        .low_speed_serial_event(ser_ls), .serial_sel_low_speed(ser_sel),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .wake_req(wake_req), .irq(irq));

    // Pulse-only sources 1, level-only 0, either capture 2
    function automatic int kind(input int i);
        if (i < 8 || i == 13 || i == 20) return 2;
        if (i < 12 || i == 22) return 1;
        return 0;
    endfunction : kind

    task automatic chk(input logic [31:0] act, input int unsigned exp);
        samples_checked++;
        if (act !== exp[31:0]) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, act, exp);
        end
    endtask : chk

    task automatic op(input logic w, r, input logic [11:0] a, input int d);
        @(posedge clk);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wdata <= d;
    endtask : op

    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 12'h0, 0);
    endtask : idle

    task automatic rd(input logic [11:0] a);
        op(1'b0, 1'b1, a, 0);
        idle(1);
        #1 got = rdata;
    endtask : rd

    task automatic chk_st();
        for (int i = 0; i < 2; i++) begin
            rd(i ? 12'h300 : 12'h100);
            chk(got, st_m[i]); // both sets see the sources
        end
    endtask : chk_st

    // Wake and pending both from status and mask
    task automatic chk_wake();
        idle(2);
        #1;
        for (int i = 0; i < 2; i++) begin
            v = (st_m[i] & ~mk_m[i]) != 0;
            chk({31'h0, wake_req[i]}, v); // wake level
            chk({31'h0, irq[i]}, v); // interrupt level
            rd(i ? 12'h30c : 12'h10c);
            chk(got, st_m[i] & ~mk_m[i]); // masked bits withheld
        end
    endtask : chk_wake

    task automatic do_reset();
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        st_m = '{32'h0, 32'h0};
        mk_m = '{32'hffffffff, 32'hffffffff};
        chk_st(); // status cleared
        rd(12'h304);
        chk(got, mk_m[1]); // all masked after reset
        chk_wake(); // no wake after reset
    endtask : do_reset

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        seed = 79395;
        clk = 1'b0;
        {wr_en, rd_en, tel_sel, ser_sel, addr, wdata, lvl, lan_idx} = '0;
        clk_en = 1'b1;
        gpio_pin = $random(seed);
        err_total = 0;
        samples_checked = 0;
        do_reset(); // first pin sample is no change
        for (b = 0; b < 29; b++) begin
            @(posedge clk);
            tel_sel <= $random(seed);
            ser_sel <= $random(seed);
            lan_idx <= 2'(($random(seed) & 32'hff) % 3);
            lvl <= 32'h1 << b;
            // Pulse sources see a single cycle only
            if (kind(b) == 1) @(posedge clk) lvl <= 32'h0;
            idle(3);
            st_m = '{32'h1 << b, 32'h1 << b};
            chk_st(); // each source on its own bit
            rd(12'h108);
            chk(got, kind(b) == 1 ? 32'h0 : 32'h1 << b); // raw lines
            @(posedge clk) lvl <= 32'h0;
            if (kind(b) != 0) op(1'b1, 1'b0, 12'h100, 32'h1 << b);
            if (kind(b) != 0) op(1'b1, 1'b0, 12'h300, 32'h1 << b);
            idle(3);
            st_m = '{32'h0, 32'h0};
            chk_st(); // level gone, sticky cleared by one
        end
        k = $random(seed) & 7;
        @(posedge clk) gpio_pin <= gpio_pin ^ (8'h1 << k);
        idle(4);
        st_m = '{32'h1 << k, 32'h1 << k};
        chk_st(); // pin change sets its bit
        for (k = 0; k < 12; k++) begin
            s = k & 1;
            base = s ? 12'h200 : 12'h0;
            v = $random(seed);
            if (k % 3 == 2) op(1'b1, 1'b0, base + 12'h160, v);
            else op(1'b1, 1'b0, base + 12'h164, v);
            if (k % 3 == 2) st_m[s] &= ~(v & wia_pkg::P2P_MASK);
            else st_m[s] |= v & wia_pkg::P2P_MASK;
            rd(base + 12'h100);
            chk(got, st_m[s]); // only addressed bits move
            v = $random(seed);
            mk_m[s] = v;
            op(1'b1, 1'b0, base + 12'h104, v);
            rd(base + 12'h104);
            chk(got, mk_m[s]); // mask per set
            chk_st(); // other set untouched
            chk_wake(); // wake follows unmasked status
        end
        // Frozen clock enable: a timer pulse and a firmware set are lost
        @(posedge clk) clk_en <= 1'b0;
        lvl <= 32'h100;
        @(posedge clk) lvl <= 32'h0;
        op(1'b1, 1'b0, 12'h164, 32'he0000000);
        idle(1);
        @(posedge clk) clk_en <= 1'b1;
        chk_st(); // nothing taken while frozen
        rd(12'h400 | 12'($random(seed)));
        chk(got, 32'h0); // unmapped reads zero
        rd(12'h160);
        chk(got, 32'h0); // clear place reads zero
        rd(12'h164);
        chk(got, st_m[0] & wia_pkg::P2P_MASK); // set place shows bits
        do_reset(); // firmware bits cleared mid-run
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire

// [bench/wia_assertions.sv]
// Checker watching the aggregator's top-level ports
`timescale 1ns/1ps
`default_nettype none
module wia_assertions (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic        pcie_ctrl_zero_event,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  wake_req,
    input wire logic [1:0]  irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence set_then_read;
        wr_en && addr == 12'h164 ##1 rd_en && addr == 12'h100;
    endsequence
    sequence clr_then_read;
        wr_en && addr == 12'h160 ##1 rd_en && addr == 12'h100;
    endsequence

    AST_IRQ_FOLLOWS_WAKE: assert property (irq == wake_req)
        else $error("irq differs from wake request");
    AST_RESET_QUIET: assert property ($fell(reset) |->
        wake_req == 2'h0 && rdata == 32'h0)
        else $error("outputs not quiet after reset");
    AST_P2P_SET: assert property (set_then_read |=>
        (rdata & $past(wdata, 2) & 32'he0000000) ==
        ($past(wdata, 2) & 32'he0000000))
        else $error("firmware set bit missing");
    AST_P2P_CLR: assert property (clr_then_read |=>
        (rdata & $past(wdata, 2) & 32'he0000000) == 32'h0)
        else $error("firmware clear bit still set");
    AST_PEND_WAKE0: assert property (rd_en && addr == 12'h10c |=>
        wake_req[0] == (rdata != 32'h0))
        else $error("set 0 wake disagrees with pending");
    AST_PEND_WAKE1: assert property (rd_en && addr == 12'h30c |=>
        wake_req[1] == (rdata != 32'h0))
        else $error("set 1 wake disagrees with pending");
    AST_MASK_HOLDS: assert property (rd_en && addr == 12'h104 |=>
        rdata != 32'hffffffff || !wake_req[0])
        else $error("fully masked set still wakes");
    AST_LEVEL_LIVE: assert property (rd_en && addr == 12'h100 &&
        $stable(pcie_ctrl_zero_event) |=>
        rdata[15] == $past(pcie_ctrl_zero_event))
        else $error("level bit does not follow its line");
endmodule : wia_assertions

bind wia_top wia_assertions u_wia_assertions (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .pcie_ctrl_zero_event(pcie_ctrl_zero_event), .rdata(rdata),
    .wake_req(wake_req), .irq(irq));
`default_nettype wire

// [bench/wia_src_model.sv]
// Interrupt source model: one level per source bit drives the lines
`timescale 1ns/1ps
`default_nettype none
module wia_src_model (
    input  wire logic [31:0] lvl,
    input  wire logic        tel_sel,
    input  wire logic        ser_sel,
    input  wire logic [1:0]  lan_idx,
    output logic      [31:0] line,
    output logic             tel_a,
    output logic             tel_b,
    output logic             ser_one,
    output logic             ser_ls,
    output logic      [2:0]  lan
);
    // no hardware line behind the firmware bits
    assign line = lvl & 32'h1fffffff;
    // unselected interface shows the opposite level
    assign tel_a = tel_sel ? ~lvl[12] : lvl[12];
    assign tel_b = tel_sel ? lvl[12] : ~lvl[12];
    // same trap for the second serial source
    assign ser_one = ser_sel ? ~lvl[26] : lvl[26];
    assign ser_ls = ser_sel ? lvl[26] : ~lvl[26];
    // only one MAC reports the wake
    assign lan = lvl[22] ? 3'h1 << lan_idx : 3'h0;
endmodule : wia_src_model
`default_nettype wire

// [common/wia_pkg.sv]
// Package for the wake interrupt aggregator: offsets, bit positions, resets
package wia_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          NUM_SRC       = 32;
    localparam int          NUM_SETS      = 2;

    // Per-set register window: set 0 packet engine, set 1 voice subsystem
    localparam logic [11:0] SET_STRIDE    = 12'h200;
    localparam logic [11:0] OFF_STATUS    = 12'h100;
    localparam logic [11:0] OFF_MASK      = 12'h104;
    localparam logic [11:0] OFF_RAW       = 12'h108;
    localparam logic [11:0] OFF_PENDING   = 12'h10c;
    localparam logic [11:0] OFF_P2P_CLR   = 12'h160;
    localparam logic [11:0] OFF_P2P_SET   = 12'h164;

    // Source bit positions
    localparam int          BIT_GPIO_LO   = 0;
    localparam int          BIT_TIMER_LO  = 8;
    localparam int          BIT_TELEPHONY = 12;
    localparam int          BIT_CLK_ALARM = 13;
    localparam int          BIT_CLK_PER   = 14;
    localparam int          BIT_PCIE0     = 15;
    localparam int          BIT_PCIE1     = 16;
    localparam int          BIT_SATA      = 17;
    localparam int          BIT_SATA_MSI  = 18;
    localparam int          BIT_USB2      = 19;
    localparam int          BIT_USB3      = 20;
    localparam int          BIT_HOST_IF   = 21;
    localparam int          BIT_LAN_WAKE  = 22;
    localparam int          BIT_VOICE     = 23;
    localparam int          BIT_DMA       = 24;
    localparam int          BIT_SERIAL0   = 25;
    localparam int          BIT_SERIAL1   = 26;
    localparam int          BIT_NOCOPY    = 27;
    localparam int          BIT_USB3_PWR  = 28;

    // Sticky (pulse) sources: GPIO, timers, alarm, USB3, LAN wake
    localparam logic [31:0] STICKY_MASK   = 32'h00502fff;
    // Firmware-only processor-to-processor bits 29..31
    localparam logic [31:0] P2P_MASK      = 32'he0000000;

    localparam logic [31:0] STATUS_RESET  = 32'h00000000;
    localparam logic [31:0] MASK_RESET    = 32'hffffffff;
endpackage : wia_pkg

// [verilog/wia_edge_detect.sv]
// Change detector for the general-purpose pins
`timescale 1ns/1ps
`default_nettype none
module wia_edge_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] change
);
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;
    logic             armed_reg;
    logic             armed_next;

    always_comb begin
        prev_next  = pin_in;
        armed_next = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_reg  <= '0;
            armed_reg <= 1'b0;
        end else if (clk_en) begin
            prev_reg  <= prev_next;
            armed_reg <= armed_next;
        end
    end

    // No change reported until a first sample is held after reset
    assign change = armed_reg ? (pin_in ^ prev_reg) : '0;
endmodule : wia_edge_detect
`default_nettype wire

// [verilog/wia_reg_set.sv]
// One status/mask register set with interrupt output
`timescale 1ns/1ps
`default_nettype none
module wia_reg_set #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] src_vec,
    input  wire logic         status_clr_we,
    input  wire logic         mask_we,
    input  wire logic         p2p_set_we,
    input  wire logic         p2p_clr_we,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] status,
    output logic      [W-1:0] mask,
    output logic      [W-1:0] pending,
    output logic              wake_next
);
    logic [W-1:0] sticky_reg;
    logic [W-1:0] sticky_next;
    logic [W-1:0] p2p_reg;
    logic [W-1:0] p2p_next;
    logic [W-1:0] mask_reg;
    logic [W-1:0] mask_next;

    always_comb begin
        // Sticky capture
        // Set wins over a same-cycle write-one clear
        sticky_next = sticky_reg;
        if (status_clr_we)
            sticky_next = sticky_next & ~wdata;
        sticky_next = (sticky_next | src_vec) & wia_pkg::STICKY_MASK;
        p2p_next = p2p_reg;
        if (p2p_clr_we)
            p2p_next = p2p_next & ~wdata;
        if (p2p_set_we)
            p2p_next = p2p_next | wdata;
        p2p_next = p2p_next & wia_pkg::P2P_MASK;
        mask_next = mask_we ? wdata : mask_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sticky_reg <= wia_pkg::STATUS_RESET;
            p2p_reg    <= wia_pkg::STATUS_RESET;
            mask_reg   <= wia_pkg::MASK_RESET;
        end else if (clk_en) begin
            sticky_reg <= sticky_next;
            p2p_reg    <= p2p_next;
            mask_reg   <= mask_next;
        end
    end

    assign status  = sticky_reg | p2p_reg
                   | (src_vec & ~wia_pkg::STICKY_MASK & ~wia_pkg::P2P_MASK);
    assign mask    = mask_reg;
    assign pending = status & ~mask_reg;
    assign wake_next = |(status & ~mask_reg);
endmodule : wia_reg_set
`default_nettype wire

// [verilog/wia_top.sv]
// Wake interrupt aggregator top: source mapping, register sets, bus slave
// Functional notes
// - Bits 0-7 carry general IRQs, also set by a change on GPIO 0-7.
// - Bits 8-11 carry timers 0-3 in order.
// - Bit 12 carries the telephony device IRQ from the interface chosen by telephony_sel_b.
// - Bits 15 and 16 carry PCIe controllers 0 and 1.
// - Bit 17 is the SATA interrupt, bit 18 the SATA message interrupt.
// - Bit 19 is USB2, bit 20 USB3, bit 28 USB3 power event.
// - Bit 22 is combined LAN wake, bit 21 the host interface event.
// - Bit 27 is the no-copy host interface event, distinct from bit 21.
// - Bit 23 carries the voice subsystem controller output.
// - Bit 24 is DMA, 25 serial port 0, 26 serial port 1 or low speed.
// - Bits 29-31 are set only by firmware writes.
// - Writes to 0x164 set and to 0x160 clear only the addressed bits.
// - Two independent register sets: packet engine and voice subsystem.
// - Each trigger has its own mask; a masked one cannot wake.
`timescale 1ns/1ps
`default_nettype none
module wia_top #(
    parameter int NUM_GPIO  = 8,
    parameter int NUM_TIMER = 4
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic [NUM_GPIO-1:0]  general_irq_line,
    input  wire logic [NUM_GPIO-1:0]  gpio_pin,
    input  wire logic [NUM_TIMER-1:0] timer_event,
    input  wire logic                 telephony_device_irq_a,
    input  wire logic                 telephony_device_irq_b,
    input  wire logic                 telephony_sel_b,
    input  wire logic                 clock_alarm_event,
    input  wire logic                 clock_periodic_event,
    input  wire logic                 pcie_ctrl_zero_event,
    input  wire logic                 pcie_ctrl_one_event,
    input  wire logic                 sata_ctrl_event,
    input  wire logic                 sata_message_signalled_event,
    input  wire logic                 usb_two_ctrl_event,
    input  wire logic                 usb_three_ctrl_event,
    input  wire logic                 usb_three_power_event,
    input  wire logic                 packet_host_if_event,
    input  wire logic                 packet_host_nocopy_event,
    input  wire logic [2:0]           lan_wakeup_event,
    input  wire logic                 voice_subsystem_event,
    input  wire logic                 peripheral_dma_event,
    input  wire logic                 serial_port_zero_event,
    input  wire logic                 serial_port_one_event,
    input  wire logic                 low_speed_serial_event,
    input  wire logic                 serial_sel_low_speed,
    input  wire logic [11:0]          addr,
    input  wire logic [31:0]          wdata,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic      [31:0]          rdata,
    output logic      [1:0]           wake_req,
    output logic      [1:0]           irq
);
    localparam int N = wia_pkg::NUM_SETS;

    logic [NUM_GPIO-1:0] gpio_change;
    logic [31:0]         src_vec;
    logic [31:0]         set_status  [N];
    logic [31:0]         set_mask    [N];
    logic [31:0]         set_pending [N];
    logic [N-1:0]        set_wake;
    logic [N-1:0]        st_we;
    logic [N-1:0]        mk_we;
    logic [N-1:0]        ps_we;
    logic [N-1:0]        pc_we;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic [N-1:0]        wake_reg;
    logic [N-1:0]        wake_next;

    // Select register set from address; 0 or 1, otherwise none
    function automatic logic [1:0] set_of(input logic [11:0] a);
        if (a < wia_pkg::SET_STRIDE)
            return 2'h0;
        else if (a < 12'(2 * wia_pkg::SET_STRIDE))
            return 2'h1;
        else
            return 2'h3;
    endfunction : set_of

    function automatic logic [11:0] off_of(input logic [11:0] a);
        return (a < wia_pkg::SET_STRIDE) ? a : a - wia_pkg::SET_STRIDE;
    endfunction : off_of

    wia_edge_detect #(
        .WIDTH (NUM_GPIO)
    ) u_gpio_edge (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .pin_in (gpio_pin),
        .change (gpio_change)
    );

    always_comb begin
        src_vec = '0;
        src_vec[wia_pkg::BIT_GPIO_LO +: NUM_GPIO] =
            general_irq_line | gpio_change;
        src_vec[wia_pkg::BIT_TIMER_LO +: NUM_TIMER] = timer_event;
        src_vec[wia_pkg::BIT_TELEPHONY] = telephony_sel_b ?
            telephony_device_irq_b : telephony_device_irq_a;
        src_vec[wia_pkg::BIT_CLK_ALARM] = clock_alarm_event;
        src_vec[wia_pkg::BIT_CLK_PER]   = clock_periodic_event;
        src_vec[wia_pkg::BIT_PCIE0]     = pcie_ctrl_zero_event;
        src_vec[wia_pkg::BIT_PCIE1]     = pcie_ctrl_one_event;
        src_vec[wia_pkg::BIT_SATA]      = sata_ctrl_event;
        src_vec[wia_pkg::BIT_SATA_MSI]  = sata_message_signalled_event;
        src_vec[wia_pkg::BIT_USB2]      = usb_two_ctrl_event;
        src_vec[wia_pkg::BIT_USB3]      = usb_three_ctrl_event;
        src_vec[wia_pkg::BIT_USB3_PWR]  = usb_three_power_event;
        // Host interface and combined LAN wake
        src_vec[wia_pkg::BIT_HOST_IF]   = packet_host_if_event;
        src_vec[wia_pkg::BIT_LAN_WAKE]  = |lan_wakeup_event;
        src_vec[wia_pkg::BIT_NOCOPY]    = packet_host_nocopy_event;
        src_vec[wia_pkg::BIT_VOICE]     = voice_subsystem_event;
        src_vec[wia_pkg::BIT_DMA]       = peripheral_dma_event;
        src_vec[wia_pkg::BIT_SERIAL0]   = serial_port_zero_event;
        src_vec[wia_pkg::BIT_SERIAL1]   = serial_sel_low_speed ?
            low_speed_serial_event : serial_port_one_event;
        // Bits 29-31 left zero here; firmware only
    end

    // Write decode per set
    always_comb begin
        for (int i = 0; i < N; i++) begin
            st_we[i] = wr_en && set_of(addr) == 2'(i)
                     && off_of(addr) == wia_pkg::OFF_STATUS;
            mk_we[i] = wr_en && set_of(addr) == 2'(i)
                     && off_of(addr) == wia_pkg::OFF_MASK;
            ps_we[i] = wr_en && set_of(addr) == 2'(i)
                     && off_of(addr) == wia_pkg::OFF_P2P_SET;
            pc_we[i] = wr_en && set_of(addr) == 2'(i)
                     && off_of(addr) == wia_pkg::OFF_P2P_CLR;
        end
    end

    for (genvar g = 0; g < N; g++) begin : g_set
        wia_reg_set #(
            .W (32)
        ) u_set (
            .clk           (clk),
            .reset         (reset),
            .clk_en        (clk_en),
            .src_vec       (src_vec),
            .status_clr_we (st_we[g]),
            .mask_we       (mk_we[g]),
            .p2p_set_we    (ps_we[g]),
            .p2p_clr_we    (pc_we[g]),
            .wdata         (wdata),
            .status        (set_status[g]),
            .mask          (set_mask[g]),
            .pending       (set_pending[g]),
            .wake_next     (set_wake[g])
        );
    end

    always_comb begin
        logic [11:0] off;
        logic [1:0]  sel;
        off        = off_of(addr);
        sel        = set_of(addr);
        rdata_next = 32'h00000000;
        if (rd_en && sel != 2'h3) begin
            case (off)
                wia_pkg::OFF_STATUS:  rdata_next = set_status[sel[0]];
                wia_pkg::OFF_MASK:    rdata_next = set_mask[sel[0]];
                wia_pkg::OFF_RAW:     rdata_next = src_vec;
                wia_pkg::OFF_PENDING: rdata_next = set_pending[sel[0]];
                // Set view of firmware bits reads status
                wia_pkg::OFF_P2P_SET:
                    rdata_next = set_status[sel[0]]
                               & wia_pkg::P2P_MASK;
                default:              rdata_next = 32'h00000000;
            endcase
        end
        wake_next = set_wake;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
            wake_reg  <= '0;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
            wake_reg  <= wake_next;
        end
    end

    assign rdata    = rdata_reg;
    assign wake_req = wake_reg;
    // Interrupt and wake share one gated condition
    assign irq      = wake_reg;
endmodule : wia_top
`default_nettype wire
